// *** design/eqm_mapper.sv ***
// eqm_mapper: turns each enqueue request into a layer-0 element and input, and
// selects the ingress drop counter for discarded copies.
// assumes requests and the register port come from logic on clock_i; no pin inputs.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps

module eqm_mapper
   import eqm_pkg::*;
#(
   parameter int VPORT_DEPTH = 1 << VPORT_W,
   parameter int ELEMENTS = NUM_ELEMENTS
)
(
   // clock, reset, enable
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // enqueue request from the forwarder
   input wire eqm_req_t req_i,
   // mapped queue and drop counter selection
   output eqm_res_t res_o,
   output eqm_drop_t drop_o
);

   localparam int CLS_W = 17;

   // mapping tables
   logic [VPORT_W-1:0] virtual_port_table [VPORT_DEPTH];
   logic [CLS_W-1:0] class_select_table [VPORT_DEPTH];
   logic [SE_W-1:0] element_lookup_table [VPORT_DEPTH];
   logic big_element_enable [ELEMENTS];
   logic [3:0] port_hierarchy_select [1 << PORT_W];
   logic [IDX_W-1:0] map_index;
   logic [CNT_W-1:0] enq_count;
   logic [CNT_W-1:0] err_count;

   // pipeline stages
   eqm_req_t s1_req;
   logic [VPORT_W-1:0] s1_vport;
   eqm_req_t s2_req;
   logic [VPORT_W-1:0] s2_vport;
   logic [PRIO_W-1:0] s2_qc;
   logic [PRIO_W-1:0] s2_dprio;
   logic [CLS_W-1:0] s2_cls;
   eqm_mode_t s2_mode;

   // combinational results of the last stage
   logic [SE_W-1:0] next_se;
   logic [INP_W-1:0] next_inp;
   logic next_size_err;
   logic [DIDX_W-1:0] next_drop_idx;

   // pick one of the four classified priorities
   function automatic logic [PRIO_W-1:0] pick_prio(input eqm_req_t r, input logic [1:0] sel);
      logic [PRIO_W-1:0] p;
      p = r.qos;
      case (sel)
         SEL_QOS: p = r.qos;
         SEL_COSID: p = r.cosid;
         SEL_PCP: p = r.pcp;
         SEL_TC: p = r.tc;
         default: p = r.qos;
      endcase
      return p;
   endfunction

   // element table index for the modes that add the class to the vport
   function automatic logic [VPORT_W-1:0] vport_plus(input logic [VPORT_W-1:0] v,
                                                     input logic [PRIO_W-1:0] c);
      return VPORT_W'(v + VPORT_W'(c));
   endfunction

   // indirect-access index cut to each table's width
   logic [VPORT_W-1:0] idx_vport;
   logic [PORT_W-1:0] idx_port;
   logic [SE_W-1:0] idx_se;
   logic idx_se_ok;
   assign idx_vport = map_index[VPORT_W-1:0];
   assign idx_port = map_index[PORT_W-1:0];
   assign idx_se = map_index[SE_W-1:0];
   assign idx_se_ok = (32'(map_index) < ELEMENTS);

   // index register: software aims every table access through it
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         map_index <= RST_MAP_INDEX;
      else if (ce_i && reg_wr_i && reg_addr_i == REG_MAP_INDEX)
         map_index <= reg_wdata_i[IDX_W-1:0];
   end

   // virtual port table; reset gives each port a block of eight vports
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         for (int i = 0; i < VPORT_DEPTH; i++)
            virtual_port_table[i] <= VPORT_W'({i[PORT_W-1:0], 3'h0});
      end
      else if (ce_i && reg_wr_i && reg_addr_i == REG_VPORT_ENTRY)
         virtual_port_table[idx_vport] <= reg_wdata_i[VPORT_W-1:0];
   end

   // class select table; reset selects the qos class and drop base zero
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         for (int i = 0; i < VPORT_DEPTH; i++)
            class_select_table[i] <= '0;
      end
      else if (ce_i && reg_wr_i && reg_addr_i == REG_CLASS_ENTRY)
         class_select_table[idx_vport] <= reg_wdata_i[CLS_W-1:0];
   end

   // element table; reset maps vport+class straight to the element number
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         for (int i = 0; i < VPORT_DEPTH; i++)
            element_lookup_table[i] <= SE_W'(i);
      end
      else if (ce_i && reg_wr_i && reg_addr_i == REG_ELEMENT_ENTRY)
         element_lookup_table[idx_vport] <= reg_wdata_i[SE_W-1:0];
   end

   // per-element size choice; an index past the last element is ignored
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         for (int i = 0; i < ELEMENTS; i++)
            big_element_enable[i] <= 1'b0;
      end
      else if (ce_i && reg_wr_i && reg_addr_i == REG_BIG_ENABLE && idx_se_ok)
         big_element_enable[idx_se] <= reg_wdata_i[0];
   end

   // per-port hierarchy modes, plain in the low pair, service in the high pair
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         for (int i = 0; i < (1 << PORT_W); i++)
            port_hierarchy_select[i] <= {RST_PORT_MODE, RST_PORT_MODE};
      end
      else if (ce_i && reg_wr_i && reg_addr_i == REG_PORT_MODE)
         port_hierarchy_select[idx_port] <= reg_wdata_i[3:0];
   end

   // stage 1: take the request and look up its virtual port
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         s1_req <= '0;
         s1_vport <= '0;
      end
      else if (ce_i)
      begin
         s1_req <= req_i;
         s1_vport <= virtual_port_table[{req_i.qgrp, req_i.dport}];
      end
   end

   // stage 2: queuing class, drop priority and hierarchy mode
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         s2_req <= '0;
         s2_vport <= '0;
         s2_qc <= '0;
         s2_dprio <= '0;
         s2_cls <= '0;
         s2_mode <= MODE_NORMAL;
      end
      else if (ce_i)
      begin
         s2_req <= s1_req;
         s2_vport <= s1_vport;
         s2_cls <= class_select_table[s1_vport];
         s2_qc <= pick_prio(s1_req, class_select_table[s1_vport][CLS_SEL_LSB +: 2]);
         s2_dprio <= pick_prio(s1_req, class_select_table[s1_vport][CLS_DPRIO_LSB +: 2]);
         // zero queue group is plain traffic, anything else is service traffic
         if (s1_req.qgrp == '0)
            s2_mode <= eqm_mode_t'(port_hierarchy_select[s1_req.dport][PMODE_PLAIN_LSB +: 2]);
         else
            s2_mode <= eqm_mode_t'(port_hierarchy_select[s1_req.dport][PMODE_SERVICE_LSB +: 2]);
      end
   end

   // stage 3 element and input; the spare mode falls back to normal mapping
   always_comb
   begin
      next_se = element_lookup_table[vport_plus(s2_vport, s2_qc)];
      next_inp = INP_W'(s2_req.sport);
      case (s2_mode)
         MODE_NORMAL:
         begin
            next_se = element_lookup_table[vport_plus(s2_vport, s2_qc)];
            next_inp = INP_W'(s2_req.sport);
         end
         MODE_GROUP:
         begin
            next_se = element_lookup_table[s2_vport];
            next_inp = INP_W'(s2_qc);
         end
         MODE_BACKHAUL:
         begin
            next_se = element_lookup_table[vport_plus(s2_vport, s2_qc)];
            next_inp = INP_W'(32'(s2_req.qgrp) % BACKHAUL_MOD);
         end
         default:
         begin
            next_se = element_lookup_table[vport_plus(s2_vport, s2_qc)];
            next_inp = INP_W'(s2_req.sport);
         end
      endcase
      // super-priority queues bypass the tables: one of two per port
      if (s2_req.super_q)
      begin
         next_se = '0;
         next_inp = INP_W'(s2_req.super_sel);
      end
   end

   // element size and queue space checks; the copy is still handed over, flagged
   always_comb
   begin
      next_size_err = 1'b0;
      if (!s2_req.super_q)
      begin
         if (32'(next_se) >= ELEMENTS)
            next_size_err = 1'b1;
         else if (big_element_enable[next_se])
            next_size_err = (32'(next_inp) >= LARGE_INPUTS);
         else
            next_size_err = (32'(next_inp) >= SMALL_INPUTS);
         if (32'(next_se) * SMALL_INPUTS + 32'(next_inp) >= TOTAL_QUEUES)
            next_size_err = 1'b1;
      end
   end

   // drop counter index: base scaled by four plus a priority
   always_comb
   begin
      logic [PRIO_W-1:0] prio;
      prio = s2_dprio;
      if (s2_cls[CLS_FOUR_BIT])
         prio[PRIO_W-1] = 1'b0;
      next_drop_idx = DIDX_W'(32'(s2_cls[CLS_BASE_LSB +: DBASE_W]) * PRIO_SCALE
                              + 32'(prio));
   end

   // stage 3 outputs; discarded copies never reach a queue
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         res_o <= '0;
      else if (ce_i)
      begin
         res_o.valid <= s2_req.valid && !s2_req.discard;
         res_o.frame_ref <= s2_req.frame_ref;
         res_o.dport <= s2_req.dport;
         res_o.sched_element <= next_se;
         res_o.inp <= next_inp;
         res_o.super_q <= s2_req.super_q;
         res_o.size_err <= next_size_err;
      end
   end

   // ingress drop counting only; egress set comes from the rewriter downstream
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         drop_o <= '0;
      else if (ce_i)
      begin
         drop_o.valid <= s2_req.valid && s2_req.discard;
         drop_o.idx <= next_drop_idx;
         drop_o.yellow <= s2_req.yellow;
         drop_o.frames_only <= s2_cls[CLS_FRAMES_BIT];
      end
   end

   // enqueue and size error counters, wrap on overflow
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         enq_count <= RST_COUNT;
         err_count <= RST_COUNT;
      end
      else if (ce_i && s2_req.valid && !s2_req.discard)
      begin
         enq_count <= CNT_W'(enq_count + 1'b1);
         if (next_size_err)
            err_count <= CNT_W'(err_count + 1'b1);
      end
   end

   // read data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         reg_rdata_o <= '0;
      else if (ce_i)
      begin
         reg_rdata_o <= '0;
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               REG_MAP_INDEX: reg_rdata_o <= 32'(map_index);
               REG_VPORT_ENTRY: reg_rdata_o <= 32'(virtual_port_table[idx_vport]);
               REG_CLASS_ENTRY: reg_rdata_o <= 32'(class_select_table[idx_vport]);
               REG_ELEMENT_ENTRY: reg_rdata_o <= 32'(element_lookup_table[idx_vport]);
               REG_PORT_MODE: reg_rdata_o <= 32'(port_hierarchy_select[idx_port]);
               REG_BIG_ENABLE: reg_rdata_o <= idx_se_ok ? 32'(big_element_enable[idx_se]) : '0;
               REG_STATUS: reg_rdata_o <= {err_count, enq_count};
               default: reg_rdata_o <= '0;
            endcase
         end
      end
   end

endmodule

// *** design/eqm_pkg.sv ***
// eqm_pkg: constants, register map and carrier types of the egress queue mapper.
// assumes one 125 MHz clock domain shared by the forwarder, the mapper and software.
package eqm_pkg;

   // widths of the request fields and of the mapping tables
   localparam int PORT_W = 4;
   localparam int QGRP_W = 6;
   localparam int PRIO_W = 3;
   localparam int FREF_W = 16;
   localparam int VPORT_W = QGRP_W + PORT_W;
   localparam int SE_W = 13;
   localparam int INP_W = 7;
   localparam int DBASE_W = 11;
   localparam int DIDX_W = 13;
   localparam int IDX_W = 16;
   localparam int CNT_W = 16;

   // element and queue population
   localparam int NUM_ELEMENTS = 5040;
   localparam int SMALL_INPUTS = 8;
   localparam int LARGE_INPUTS = 72;
   localparam int TOTAL_QUEUES = 40460;
   localparam int NUM_DROP_SETS = 8192;
   localparam int PRIO_SCALE = 4;
   localparam int BACKHAUL_MOD = 64;
   localparam int LOOKUP_LATENCY = 3;

   // drop counter split: octets and frames share one 28-bit word
   localparam int DROP_OCTET_BITS = 18;
   localparam int DROP_FRAME_BITS = 10;

   // register byte addresses (word aligned)
   localparam logic [7:0] REG_MAP_INDEX = 8'h00;
   localparam logic [7:0] REG_VPORT_ENTRY = 8'h04;
   localparam logic [7:0] REG_CLASS_ENTRY = 8'h08;
   localparam logic [7:0] REG_ELEMENT_ENTRY = 8'h0C;
   localparam logic [7:0] REG_PORT_MODE = 8'h10;
   localparam logic [7:0] REG_BIG_ENABLE = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;

   // field positions inside the class select entry
   localparam int CLS_SEL_LSB = 0;
   localparam int CLS_DPRIO_LSB = 2;
   localparam int CLS_BASE_LSB = 4;
   localparam int CLS_FOUR_BIT = 15;
   localparam int CLS_FRAMES_BIT = 16;

   // field positions inside the port mode register
   localparam int PMODE_PLAIN_LSB = 0;
   localparam int PMODE_SERVICE_LSB = 2;

   // reset values
   localparam logic [IDX_W-1:0] RST_MAP_INDEX = 16'h0000;
   localparam logic [1:0] RST_PORT_MODE = 2'h0;
   localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;

   // hierarchy modes and class selectors
   typedef enum logic [1:0] {MODE_NORMAL, MODE_GROUP, MODE_BACKHAUL, MODE_SPARE} eqm_mode_t;
   typedef enum logic [1:0] {SEL_QOS, SEL_COSID, SEL_PCP, SEL_TC} eqm_sel_t;

   // one enqueue request from the forwarder
   typedef struct packed {
      logic valid;
      logic [FREF_W-1:0] frame_ref;
      logic [QGRP_W-1:0] qgrp;
      logic [PORT_W-1:0] dport;
      logic [PORT_W-1:0] sport;
      logic [PRIO_W-1:0] qos;
      logic [PRIO_W-1:0] cosid;
      logic [PRIO_W-1:0] pcp;
      logic [PRIO_W-1:0] tc;
      logic super_q;
      logic super_sel;
      logic discard;
      logic yellow;
   } eqm_req_t;

   // mapped queue handed to the queue system
   typedef struct packed {
      logic valid;
      logic [FREF_W-1:0] frame_ref;
      logic [PORT_W-1:0] dport;
      logic [SE_W-1:0] sched_element;
      logic [INP_W-1:0] inp;
      logic super_q;
      logic size_err;
   } eqm_res_t;

   // ingress drop counter selection
   typedef struct packed {
      logic valid;
      logic [DIDX_W-1:0] idx;
      logic yellow;
      logic frames_only;
   } eqm_drop_t;

endpackage

// *** verif/eqm_mapper_asserts.sv ***
// eqm_mapper_asserts: port-level checks of the egress queue mapper.
// assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ps
module eqm_mapper_asserts
   import eqm_pkg::*;
#(
   parameter int VPORT_DEPTH = 1 << VPORT_W,
   parameter int ELEMENTS = NUM_ELEMENTS
)
(
   // clock and control
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   // enqueue path
   input wire eqm_req_t req_i,
   input wire eqm_res_t res_o,
   input wire eqm_drop_t drop_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   // outputs must be quiet on the first edge after reset
   reset_clear_a: assert property ($past(srst_i) |-> res_o == '0 && drop_o == '0)
      else $error("outputs not cleared by reset");
   rdata_idle_a: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data outside its cycle");
   unmapped_read_a: assert property (reg_rd_i && reg_addr_i >= 8'h1C |=> reg_rdata_o == 32'h0)
      else $error("unmapped address returned data");
   // index written, one idle cycle, then read back
   index_readback_a: assert property ((reg_wr_i && reg_addr_i == REG_MAP_INDEX) ##1 !reg_wr_i
      ##1 (reg_rd_i && reg_addr_i == REG_MAP_INDEX) |=>
      reg_rdata_o[15:0] == $past(reg_wdata_i[15:0], 3)) else $error("map index read back wrong");
   res_latency_a: assert property ((ce_i && req_i.valid && !req_i.discard) ##1 ce_i[*2]
      |=> res_o.valid && res_o.frame_ref == $past(req_i.frame_ref, 3)
      && res_o.dport == $past(req_i.dport, 3)) else $error("mapped copy late or altered");
   drop_latency_a: assert property ((ce_i && req_i.valid && req_i.discard) ##1 ce_i[*2]
      |=> drop_o.valid && !res_o.valid && drop_o.yellow == $past(req_i.yellow, 3))
      else $error("drop selection late or wrong colour");
   // a mapped copy always has a non-discarded request behind it
   // a frozen pipeline holds its result, so only judge it after three enabled edges
   no_spurious_a: assert property (res_o.valid && $past(ce_i)
      && $past(ce_i, 2) && $past(ce_i, 3) |-> $past(req_i.valid, 3)
      && !$past(req_i.discard, 3)) else $error("mapped copy without request");
   super_path_a: assert property ((ce_i && req_i.valid && req_i.super_q && !req_i.discard)
      ##1 ce_i[*2] |=> res_o.super_q && res_o.sched_element == '0 && !res_o.size_err
      && res_o.inp == INP_W'($past(req_i.super_sel, 3))) else $error("super queue mapping wrong");

   // main scenarios reached
   map_seen_c: cover property (res_o.valid && !res_o.size_err);
   err_seen_c: cover property (res_o.valid && res_o.size_err);
   drop_seen_c: cover property (drop_o.valid && drop_o.frames_only);
endmodule

bind eqm_mapper eqm_mapper_asserts #(.VPORT_DEPTH(VPORT_DEPTH), .ELEMENTS(ELEMENTS))
   eqm_mapper_asserts_i (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i), .res_o(res_o),
   .drop_o(drop_o));

// *** verif/eqm_mapper_test.sv ***
// eqm_mapper_test: register tasks and mapping scenarios for the queue mapper.
// assumes the mapper's reset defaults and a 3-cycle lookup pipeline.
`timescale 1ns/1ps
module eqm_mapper_test;
   import eqm_pkg::*;
   logic clock_i;
   logic srst_i;
   logic ce_i;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i;
   logic reg_wr_i;
   logic reg_rd_i;
   logic [31:0] reg_rdata_o;
   eqm_req_t req_i;
   eqm_res_t res_o;
   eqm_drop_t drop_o;
   logic [15:0] mapped_count;
   logic [15:0] drop_count;
   int fail_count = 0;
   int samples_checked = 0;

   eqm_mapper eqm_mapper_i (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i), .res_o(res_o),
      .drop_o(drop_o));
   eqm_queue_sink eqm_queue_sink_i (.clock_i(clock_i), .srst_i(srst_i), .res_i(res_o),
      .drop_i(drop_o), .mapped_count_o(mapped_count), .drop_count_o(drop_count));

   // 125 MHz clock
   always #4 clock_i = ~clock_i;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, exp);
   endtask

   function automatic eqm_req_t mk(input logic [5:0] g, input logic [3:0] dp,
      input logic [3:0] sp, input logic [11:0] pr, input logic dis, input logic yel);
      eqm_req_t r;
      r = '0;
      r.valid = 1'b1;
      r.frame_ref = {g, dp, sp, 2'h2};
      r.qgrp = g;
      r.dport = dp;
      r.sport = sp;
      {r.qos, r.cosid, r.pcp, r.tc} = pr;
      r.discard = dis;
      r.yellow = yel;
      return r;
   endfunction

   // request valid for one cycle; result is sampled in its third cycle after
   task automatic send(input eqm_req_t r);
      @(posedge clock_i);
      req_i <= r;
      @(posedge clock_i);
      req_i <= '0;
      repeat (2) @(posedge clock_i);
      #1;
   endtask

   task automatic cres(input logic [12:0] se, input logic [6:0] inp, input logic err);
      chk({res_o.valid, res_o.sched_element, res_o.inp, res_o.size_err}, {1'b1, se, inp, err});
   endtask

   task automatic cdrop(input logic [12:0] idx, input logic yel, input logic fo);
      chk({drop_o.valid, drop_o.idx, drop_o.yellow, drop_o.frames_only}, {1'b1, idx, yel, fo});
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // watchdog, far beyond the hundred or so cycles the tests need
   initial
   begin
      #100000;
      fail_count++;
      wrap_up();
   end

   initial
   begin
      clock_i = 1'b0;
      srst_i = 1'b1;
      ce_i = 1'b1;
      reg_addr_i = 8'h00;
      reg_wdata_i = 32'h0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      req_i = '0;
      repeat (12) @(posedge clock_i);
      srst_i <= 1'b0;
      rd(REG_MAP_INDEX, 32'h0);
      rd(8'h1C, 32'h0);
      send(mk(6'h00, 4'h0, 4'h7, 12'h000, 1'b0, 1'b0));
      cres(13'h0000, 7'h07, 1'b0);
      send(mk(6'h00, 4'h2, 4'h3, 12'hA00, 1'b0, 1'b0));
      cres(13'h0015, 7'h03, 1'b0);
      send('{valid: 1'b1, dport: 4'h4, super_q: 1'b1, super_sel: 1'b1, default: '0});
      cres(13'h0000, 7'h01, 1'b0);
      // enable low for two cycles holds the request in stage 1, so it leaves two cycles late
      @(posedge clock_i);
      req_i <= mk(6'h00, 4'h0, 4'h7, 12'h000, 1'b0, 1'b0);
      @(posedge clock_i);
      req_i <= '0;
      ce_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      ce_i <= 1'b1;
      #1;
      chk({31'h0, res_o.valid}, 32'h0);
      repeat (2) @(posedge clock_i);
      #1;
      cres(13'h0000, 7'h07, 1'b0);
      $display("defaults test done");
      wr(REG_MAP_INDEX, 32'h1E);
      rd(REG_MAP_INDEX, 32'h1E);
      wr(REG_ELEMENT_ENTRY, 32'h123);
      rd(REG_ELEMENT_ENTRY, 32'h123);
      rd(REG_MAP_INDEX, 32'h1E);
      $display("indirect access test done");
      wr(REG_MAP_INDEX, 32'h1);
      wr(REG_PORT_MODE, 32'h9);
      send(mk(6'h00, 4'h1, 4'h2, 12'hA00, 1'b0, 1'b0));
      cres(13'h0008, 7'h05, 1'b0);
      send(mk(6'h25, 4'h1, 4'h2, 12'h400, 1'b0, 1'b0));
      cres(13'h000A, 7'h25, 1'b1);
      wr(REG_MAP_INDEX, 32'hA);
      wr(REG_BIG_ENABLE, 32'h1);
      send(mk(6'h25, 4'h1, 4'h2, 12'h400, 1'b0, 1'b0));
      cres(13'h000A, 7'h25, 1'b0);
      $display("hierarchy mode test done");
      wr(REG_MAP_INDEX, 32'h18);
      for (int s = 0; s < 4; s++)
      begin
         wr(REG_CLASS_ENTRY, 32'(s));
         send(mk(6'h00, 4'h3, 4'h9, 12'h29C, 1'b0, 1'b0));
         cres(13'(25 + s), 7'h09, 1'b1);
      end
      send(mk(6'h00, 4'h3, 4'h9, 12'h29E, 1'b0, 1'b0));
      cres(13'h0123, 7'h09, 1'b1);
      $display("class select test done");
      wr(REG_CLASS_ENTRY, 32'h1805F);
      send(mk(6'h00, 4'h3, 4'h9, 12'h29E, 1'b1, 1'b1));
      cdrop(13'h0016, 1'b1, 1'b1);
      wr(REG_CLASS_ENTRY, 32'h5F);
      send(mk(6'h00, 4'h3, 4'h9, 12'h29E, 1'b1, 1'b0));
      cdrop(13'h001A, 1'b0, 1'b0);
      rd(REG_CLASS_ENTRY, 32'h5F);
      rd(REG_STATUS, 32'h0006000C);
      $display("drop index test done");
      repeat (2) @(posedge clock_i);
      #1;
      chk({16'h0, mapped_count}, 32'hC);
      chk({16'h0, drop_count}, 32'h2);
      wrap_up();
   end
endmodule

// *** verif/eqm_queue_sink.sv ***
// eqm_queue_sink: queue system side, takes mapped copies and drop selections.
// assumes results arrive as one-cycle valid pulses on clock_i.
`timescale 1ns/1ps
module eqm_queue_sink
   import eqm_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // results from the mapper
   input wire eqm_res_t res_i,
   input wire eqm_drop_t drop_i,
   // tallies for the bench
   output logic [15:0] mapped_count_o,
   output logic [15:0] drop_count_o
);
   // counting every pulse exposes duplicate or missing results
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         mapped_count_o <= 16'h0000;
         drop_count_o <= 16'h0000;
      end
      else
      begin
         mapped_count_o <= mapped_count_o + {15'h0000, res_i.valid};
         drop_count_o <= drop_count_o + {15'h0000, drop_i.valid};
      end
   end
endmodule
